// >>> hdl/sfph_pkg.sv
// ============================================================================
// Shared constants and types for the serial flash protection and hold front.
// Assumes one 20 MHz system clock that samples every serial pin.
package sfph_pkg;
    // ========================================================================
    // Array geometry: 64K-byte blocks of 4K-byte sectors.
    localparam int          ADDR_W      = 24;
    localparam int          BLK_LSB     = 16;
    localparam int          BLK_W       = 7;
    localparam int          SEC_LSB     = 12;
    localparam int          SEC_W       = 11;
    localparam int          OTP_ROW_BIT = 9;
    localparam logic [23:0] ARRAY_TOP   = 24'h7FFFFF;

    // ========================================================================
    // Command opcodes.
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATUS     = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS    = 8'h01;
    localparam logic [7:0] OP_READ            = 8'h03;
    localparam logic [7:0] OP_PAGE_PROG       = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE   = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE     = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A    = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B    = 8'hC7;
    localparam logic [7:0] OP_ENTER_SECURED   = 8'hA1;
    localparam logic [7:0] OP_EXIT_SECURED    = 8'hA2;
    localparam logic [7:0] OP_WRITE_SECUR     = 8'hA3;
    localparam logic [7:0] OP_READ_SECUR      = 8'hA4;

    // ========================================================================
    // Register field positions and values after reset.
    localparam int         STAT_WIP    = 0;
    localparam int         STAT_WEL    = 1;
    localparam int         STAT_BP_LSB = 2;
    localparam int         CFG_TB      = 3;
    localparam int         SECUR_FAC   = 0;
    localparam int         SECUR_CUST  = 1;
    localparam logic [3:0] RST_BP      = 4'h0;
    localparam logic       RST_TB      = 1'b0;

    // ========================================================================
    // Byte counts that a frame must end on to execute.
    localparam logic [2:0] LEN_SHORT    = 3'h1;
    localparam logic [2:0] LEN_WRSR1    = 3'h2;
    localparam logic [2:0] LEN_WRSR2    = 3'h3;
    localparam logic [2:0] LEN_ADDR     = 3'h4;
    localparam logic [2:0] LEN_PROG_MIN = 3'h5;
    localparam logic [2:0] LEN_SAT      = 3'h7;

    // ========================================================================
    // Types.
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_CMD    = 6'h02,
        ST_ADDR   = 6'h04,
        ST_DIN    = 6'h08,
        ST_OUT    = 6'h10,
        ST_REJECT = 6'h20
    } sfph_state_e;

    typedef enum logic [2:0] {
        K_READ = 3'h0,
        K_PROG = 3'h1,
        K_SE   = 3'h2,
        K_BE32 = 3'h3,
        K_BE   = 3'h4,
        K_CE   = 3'h5
    } sfph_kind_e;

    typedef struct packed {
        logic              valid;
        sfph_kind_e        kind;
        logic              otp;
        logic [ADDR_W-1:0] addr;
    } sfph_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sfph_byte_s;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
        logic hold_n;
    } sfph_pins_s;

    localparam sfph_pins_s PINS_RST = 4'h9;
endpackage

// >>> hdl/sfph_sync.sv
// ============================================================================
// Two-stage synchroniser for the serial pins.
// Assumes pins are asynchronous to clk_i; only stage two is read outside.
`timescale 1ns/100ps
module sfph_sync
    import sfph_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Pins
    input  wire sfph_pins_s pins_i,
    output sfph_pins_s      pins_o
);
    typedef struct packed {
        sfph_pins_s meta;
        sfph_pins_s sync;
    } sfph_sync_s;

    sfph_sync_s q;
    sfph_sync_s d;

    // The first stage feeds only the second stage.
    always_comb begin
        d      = q;
        d.meta = pins_i;
        d.sync = q.meta;
    end

    // Idle levels after reset keep the front end deselected.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= {PINS_RST, PINS_RST};
        end else begin
            q <= d;
        end
    end

    assign pins_o = q.sync;
endmodule

// >>> hdl/sfph_prot_map.sv
// ============================================================================
// Block protection decoder: is a 64K-byte block inside the protected range.
// Purely combinational; the caller feeds it from registered state and uses the result unregistered.
`timescale 1ns/100ps
module sfph_prot_map
    import sfph_pkg::*;
(
    // Protection setting
    input  wire logic [3:0]       level_i,
    input  wire logic             tb_i,
    // Block under test
    input  wire logic [BLK_W-1:0] blk_i,
    output logic                  prot_o
);
    // Bottom mode uses the block number, top mode its mirror 127 - n.
    function automatic logic prot_hit(input logic [3:0] lv, input logic tb,
                                      input logic [BLK_W-1:0] blk);
        logic [BLK_W:0] m;
        m = {1'b0, (tb ? blk : ~blk)};
        case (lv)
            4'h0:                   prot_hit = 1'b0;
            4'h7, 4'h8, 4'hF:       prot_hit = 1'b1;
            4'h1, 4'h2, 4'h3,
            4'h4, 4'h5, 4'h6:       prot_hit = m < (8'h01 << lv);
            default:                prot_hit = m >= (8'h01 << (4'hF - lv));
        endcase
    endfunction

    assign prot_o = prot_hit(level_i, tb_i, blk_i);
endmodule

// >>> hdl/sfph_front.sv
// ============================================================================
// Serial flash front end: command framing, write latch, block protection,
// secured OTP rows and locks, and the pause (hold) function.
// Assumes the core returns read data within four clocks of a read request.
`timescale 1ns/100ps

// Summary of operation
// - Bottom mode: codes 1 to 6 protect lowest 2..64 blocks.
// - Codes 7, 8, 15 protect all 128 blocks; code 0 none.
// - Bottom mode: codes 9 to 14 protect from block 64..2 to 127.
// - Chip erase executes only when all four protect bits are zero.
// - OTP area is two 4096-bit rows: customer low, factory high.
// - Security bit 0 shows the factory lock of the upper row.
// - Write-security command locks customer row and sets security bit 1.
// - A locked row refuses every further change.
// - Secured mode blocks all main array access.
// - 64K-byte blocks of 4K-byte sectors up to address 7FFFFF.
// - Invalid command idles with output off until next select.
// - Sample on clock rise, shift out on fall; modes 0 and 3.
// - Read-type commands may end after any output bit.
// - Write-type commands execute only if select rises on a byte boundary.
// - Array access is ignored while an internal operation runs.
// - Pause never disturbs an internal write, program or erase.
// - Pause starts on hold low with select low, deferred until clock low.
// - Pause ends on hold high, deferred until clock low.
// - During pause output is off and input is ignored.
// - Select rising during pause resets the interface.
// - Pause is disabled in four-line data mode.
// - Top mode mirrors the ranges downward from block 127.
// - Data-changing commands need the write enable latch set.
module sfph_front
    import sfph_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Serial pins
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic       si_i,
    input  wire logic       hold_n_i,
    output logic            so_o,
    output logic            so_oe_o,
    // Core side
    input  wire logic       busy_i,
    input  wire logic       quad_mode_i,
    input  wire logic       factory_lock_i,
    input  wire logic [7:0] array_data_i,
    output sfph_req_s       req_o,
    output sfph_byte_s      prog_byte_o,
    // Status
    output logic            write_enable_latch_o,
    output logic            otp_mode_o,
    output logic [3:0]      protect_level_o,
    output logic            top_bottom_o,
    output logic [1:0]      secur_o,
    output logic            held_o
);
    // ========================================================================
    // State.
    typedef struct packed {
        sfph_state_e       st;
        logic [2:0]        bitc;
        logic [2:0]        bytec;
        logic [2:0]        obit;
        logic [7:0]        shreg;
        logic [7:0]        opcode;
        logic [7:0]        data0;
        logic [7:0]        data1;
        logic [7:0]        outbuf;
        logic [ADDR_W-1:0] addr;
        logic              write_enable_latch;
        logic              otp;
        logic              cust;
        logic              fac;
        logic              tb;
        logic [3:0]        bp;
        logic              held;
        logic              sclk_p;
        logic              cs_p;
        logic              so;
        logic              so_oe;
        sfph_req_s         req;
        sfph_byte_s        wb;
    } sfph_front_s;

    sfph_front_s q;
    sfph_front_s d;
    sfph_pins_s  pin;
    logic        prot;

    sfph_sync u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pins_i  ({cs_n_i, sclk_i, si_i, hold_n_i}),
        .pins_o  (pin)
    );

    // The block field of the latched address selects the protection test.
    sfph_prot_map u_prot (
        .level_i (q.bp),
        .tb_i    (q.tb),
        .blk_i   (q.addr[BLK_LSB +: BLK_W]),
        .prot_o  (prot)
    );

    // ========================================================================
    // Next state.
    always_comb begin
        logic       rise;
        logic       fall;
        logic       row_lock;
        logic       go;
        logic [7:0] nb;
        logic [7:0] src;
        logic [7:0] stat;
        rise = 1'b0;
        fall = 1'b0;
        row_lock = q.addr[OTP_ROW_BIT] ? q.fac : q.cust;
        go = 1'b0;
        nb = {q.shreg[6:0], pin.si};
        src = 8'h00;
        stat = 8'h00;
        stat[STAT_WIP] = busy_i;
        stat[STAT_WEL] = q.write_enable_latch;
        stat[STAT_BP_LSB +: 4] = q.bp;

        d = q;
        d.req.valid = 1'b0;
        d.wb.valid = 1'b0;
        d.sclk_p = pin.sclk;
        d.cs_p = pin.cs_n;
        d.fac = q.fac | factory_lock_i;

        if (pin.cs_n) begin
            // Select high ends the frame; writes execute only on a byte boundary.
            if (!q.cs_p && q.bitc == 3'h0 && q.st != ST_REJECT) begin
                go = q.write_enable_latch && !busy_i;
                case (q.opcode)
                    OP_SET_WRITE_LATCH: begin
                        if (q.bytec == LEN_SHORT) d.write_enable_latch = 1'b1;
                    end
                    OP_CLR_WRITE_LATCH: begin
                        if (q.bytec == LEN_SHORT) d.write_enable_latch = 1'b0;
                    end
                    OP_ENTER_SECURED: begin
                        if (q.bytec == LEN_SHORT) d.otp = 1'b1;
                    end
                    OP_EXIT_SECURED: begin
                        if (q.bytec == LEN_SHORT) d.otp = 1'b0;
                    end
                    OP_WRITE_SECUR: begin
                        if (q.bytec == LEN_SHORT && go) begin
                            d.cust = 1'b1;
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    OP_WRITE_STATUS: begin
                        if ((q.bytec == LEN_WRSR1 || q.bytec == LEN_WRSR2) && go) begin
                            d.bp = q.data0[STAT_BP_LSB +: 4];
                            if (q.bytec == LEN_WRSR2) d.tb = q.data1[CFG_TB];
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    OP_PAGE_PROG: begin
                        if (q.bytec >= LEN_PROG_MIN && go && (q.otp ? !row_lock : !prot)) begin
                            d.req = '{1'b1, K_PROG, q.otp, q.addr};
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK_ERASE: begin
                        if (q.bytec == LEN_ADDR && go && !q.otp && !prot) begin
                            d.req.valid = 1'b1;
                            d.req.kind = (q.opcode == OP_SECTOR_ERASE) ? K_SE :
                                         (q.opcode == OP_BLOCK_ERASE) ? K_BE : K_BE32;
                            d.req.otp = 1'b0;
                            d.req.addr = q.addr;
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                        if (q.bytec == LEN_SHORT && go && !q.otp && q.bp == 4'h0) begin
                            d.req = '{1'b1, K_CE, 1'b0, '0};
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Any rise of select, held or not, clears the interface logic.
            d.st = ST_IDLE;
            d.held = 1'b0;
            d.so_oe = 1'b0;
        end else if (q.cs_p) begin
            // Select fall opens a frame whatever the clock level (mode 0 or 3).
            d.st = ST_CMD;
            d.bitc = 3'h0;
            d.bytec = 3'h0;
            d.obit = 3'h0;
            d.opcode = 8'h00;
        end else begin
            // Pause follows the pin levels only while the clock is low.
            if (!q.held && !pin.hold_n && !pin.sclk && !quad_mode_i) begin
                d.held = 1'b1;
            end else if (q.held && (pin.hold_n || quad_mode_i) && !pin.sclk) begin
                d.held = 1'b0;
            end
            rise = pin.sclk && !q.sclk_p && !q.held;
            fall = !pin.sclk && q.sclk_p && !q.held;

            // Input bits are taken on rising clock edges.
            if (rise && (q.st == ST_CMD || q.st == ST_ADDR || q.st == ST_DIN)) begin
                d.shreg = nb;
                d.bitc = q.bitc + 3'h1;
                if (q.bitc == 3'h7) begin
                    d.bytec = (q.bytec == LEN_SAT) ? q.bytec : q.bytec + 3'h1;
                    case (q.st)
                        ST_CMD: begin
                            d.opcode = nb;
                            case (nb)
                                OP_READ, OP_PAGE_PROG, OP_SECTOR_ERASE,
                                OP_BLOCK32_ERASE, OP_BLOCK_ERASE:
                                    d.st = ST_ADDR;
                                OP_READ_STATUS, OP_READ_SECUR:
                                    d.st = ST_OUT;
                                OP_SET_WRITE_LATCH, OP_CLR_WRITE_LATCH, OP_ENTER_SECURED,
                                OP_EXIT_SECURED, OP_WRITE_SECUR, OP_WRITE_STATUS,
                                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
                                    d.st = ST_DIN;
                                default:
                                    d.st = ST_REJECT;
                            endcase
                        end
                        ST_ADDR: begin
                            d.addr = {q.addr[15:0], nb};
                            if (q.bytec == LEN_ADDR - 3'h1) begin
                                if (q.opcode != OP_READ) begin
                                    d.st = ST_DIN;
                                end else if (busy_i) begin
                                    d.st = ST_REJECT;
                                end else begin
                                    d.st = ST_OUT;
                                    d.req = '{1'b1, K_READ, q.otp, {q.addr[15:0], nb} & ARRAY_TOP};
                                end
                            end
                        end
                        default: begin
                            if (q.bytec == LEN_SHORT) d.data0 = nb;
                            if (q.bytec == LEN_WRSR1) d.data1 = nb;
                            if (q.opcode == OP_PAGE_PROG) d.wb = '{1'b1, nb};
                        end
                    endcase
                end
            end

            // Output bits are shifted on falling clock edges.
            if (fall && q.st == ST_OUT) begin
                case (q.opcode)
                    OP_READ:        src = array_data_i;
                    OP_READ_STATUS: src = stat;
                    default:        src = {6'h00, q.cust, q.fac};
                endcase
                if (q.obit != 3'h0) src = q.outbuf;
                d.so = src[7];
                d.outbuf = {src[6:0], 1'b0};
                d.obit = q.obit + 3'h1;
                if (q.opcode == OP_READ && q.obit == 3'h7 && !busy_i) begin
                    d.addr = (q.addr + 24'h000001) & ARRAY_TOP;
                    d.req = '{1'b1, K_READ, q.otp, (q.addr + 24'h000001) & ARRAY_TOP};
                end
            end
            d.so_oe = (d.st == ST_OUT) && !d.held;
        end
    end

    // ========================================================================
    // State register. Requests already passed to the core are never
    // recalled by a pause, so an internal operation runs to its end.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.cs_p <= 1'b1;
            q.bp <= RST_BP;
            q.tb <= RST_TB;
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs, all taken straight from the state register.
    assign so_o                 = q.so;
    assign so_oe_o              = q.so_oe;
    assign req_o                = q.req;
    assign prog_byte_o          = q.wb;
    assign write_enable_latch_o = q.write_enable_latch;
    assign otp_mode_o           = q.otp;
    assign protect_level_o      = q.bp;
    assign top_bottom_o         = q.tb;
    assign secur_o              = {q.cust, q.fac};
    assign held_o               = q.held;

    // ========================================================================
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    held_quiet_a: assert property (q.held |-> !q.so_oe) else $error("output on during pause");
    oe_state_a: assert property (q.so_oe |-> q.st == ST_OUT) else $error("output on outside data out");
    ce_guard_a: assert property (req_o.valid && req_o.kind == K_CE |-> $past(q.bp) == 4'h0)
        else $error("chip erase with protection set");
    wel_need_a: assert property (req_o.valid && req_o.kind != K_READ |-> $past(q.write_enable_latch) && !q.write_enable_latch)
        else $error("write request without latch");
    otp_route_a: assert property (req_o.valid |-> req_o.otp == $past(q.otp))
        else $error("array access in secured mode");
    prot_block_a: assert property (req_o.valid && req_o.kind != K_READ && !req_o.otp |-> !$past(prot))
        else $error("write into protected block");
    busy_ignore_a: assert property (req_o.valid |-> !$past(busy_i)) else $error("request while busy");
    lock_sticky_a: assert property (q.cust |=> q.cust) else $error("customer lock cleared");
    cs_clear_a: assert property (pin.cs_n && !q.cs_p |=> q.st == ST_IDLE && !q.held)
        else $error("select rise kept interface");
    quad_nohold_a: assert property (quad_mode_i && !q.held |=> !q.held) else $error("pause in quad mode");

    prog_seen_c: cover property (req_o.valid && req_o.kind == K_PROG);
    pause_seen_c: cover property (q.held ##1 !q.held && q.st == ST_OUT);
    chip_erase_c: cover property (req_o.valid && req_o.kind == K_CE);
endmodule

// >>> testbench/sfph_host_model.sv
// Host controller model driving select, serial clock, data and pause pins.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/100ps
module sfph_host_model (
    // Clock
    input  wire logic clk_i,
    // Serial pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      si_o,
    output logic      hold_n_o
);
    // ========================================================================
    // Idle levels: clock stands low between frames, as in mode 0.
    initial begin
        cs_n_o   = 1'b1;
        sclk_o   = 1'b0;
        si_o     = 1'b0;
        hold_n_o = 1'b1;
    end
    // Wait whole system clocks.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Select or release; the data line flips so no stale bit lingers.
    // The wait after a change covers the design's synchroniser and register delay.
    task automatic sel(input logic v);
        tick(4);
        cs_n_o <= v;
        si_o   <= ~si_o;
        tick(8);
    endtask
    // Shift n bits MSB first; data moves only while the clock is low.
    task automatic shift(input logic [31:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            si_o   <= d[i];
            tick(4);
            sclk_o <= 1'b1;
            tick(4);
            sclk_o <= 1'b0;
        end
    endtask
    // A complete frame; n sets whether it ends on a byte boundary.
    task automatic frame(input logic [31:0] d, input int n);
        sel(1'b0);
        shift(d, n);
        sel(1'b1);
    endtask
    // Pause pin moved only while the clock stands low.
    task automatic pause(input logic v);
        hold_n_o <= v;
        tick(8);
    endtask
endmodule

// >>> testbench/sfph_front_bench.sv
// Bench for the serial flash front: host frames in, port values checked.
// Assumes effects settle within eight clocks of select rising.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, a); end end
module sfph_front_bench;
    import sfph_pkg::*;
    logic       clk_i = 1'b0, reset_i = 1'b1, factory_lock_i = 1'b0;
    logic       cs_n_i, sclk_i, si_i, hold_n_i, so_o, so_oe_o, write_enable_latch, otp, tb, held;
    logic       busy = 1'b0, quad = 1'b0;
    logic [7:0] rdata = 8'h3C, lastb, v;
    logic [3:0] level;
    logic [1:0] secur;
    sfph_req_s  req_o, last;
    sfph_byte_s pb;
    int         mismatches = 0, n_tests = 0, nreq = 0, cyc = 0;
    // ========================================================================
    // Busy, four-line mode and read data are bench variables so each is exercised.
    sfph_front dut (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
        .si_i(si_i), .hold_n_i(hold_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .busy_i(busy),
        .quad_mode_i(quad), .factory_lock_i(factory_lock_i), .array_data_i(rdata),
        .req_o(req_o), .prog_byte_o(pb), .write_enable_latch_o(write_enable_latch), .otp_mode_o(otp),
        .protect_level_o(level), .top_bottom_o(tb), .secur_o(secur), .held_o(held));
    sfph_host_model host (.clk_i(clk_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i),
        .hold_n_o(hold_n_i));
    always #25 clk_i = ~clk_i;
    // Report counts and verdict, then stop.
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Latch request pulses, since each stands for one clock only; cut hangs.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (req_o.valid === 1'b1) begin
            nreq <= nreq + 1;
            last <= req_o;
        end
        if (pb.valid === 1'b1) begin
            lastb <= pb.data;
        end
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    // Write latch first, then the data-changing frame.
    task automatic wr(input logic [31:0] d, input int n);
        host.frame(32'h06, 8);
        host.frame(d, n);
    endtask
    // Write latch, then a page program of one data byte.
    task automatic pp(input logic [31:0] a);
        host.frame(32'h06, 8);
        host.sel(1'b0);
        host.shift(a, 32);
        host.shift(32'h5A, 8);
        host.sel(1'b1);
    endtask
    // Collect one output byte, sampling after each falling clock has settled.
    task automatic rd_byte(output logic [7:0] b);
        for (int k = 0; k < 8; k++) begin
            host.tick(6);
            b = {b[6:0], so_o};
            host.shift(32'h0, 1);
        end
    endtask
    // ========================================================================
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        host.tick(8);
        `CHK("wel", 1'b0, write_enable_latch)
        host.frame(32'h06, 8);
        `CHK("wel", 1'b1, write_enable_latch)
        host.frame(32'h010408, 24);
        `CHK("level", 4'h1, level)
        `CHK("tb", 1'b1, tb)
        wr(32'h2001FFFF, 32);
        `CHK("protected erase", 0, nreq)
        wr(32'h20020000, 32);
        `CHK("open erase", 1, nreq)
        `CHK("erase addr", 24'h020000, last.addr)
        `CHK("erase kind", K_SE, last.kind)
        wr(32'h60, 8);
        `CHK("chip erase refused", 1, nreq)
        wr(32'h00200, 17);
        `CHK("partial frame", 4'h1, level)
        wr(32'h010008, 24);
        `CHK("level zero", 4'h0, level)
        wr(32'hC7, 8);
        `CHK("chip erase", 2, nreq)
        `CHK("chip erase kind", K_CE, last.kind)
        wr(32'h010400, 24);
        wr(32'h207F0000, 32);
        `CHK("top block", 2, nreq)
        wr(32'h20000000, 32);
        `CHK("bottom block", 3, nreq)
        host.frame(32'hA1, 8);
        `CHK("secured mode", 1'b1, otp)
        host.frame(32'hA2, 8);
        `CHK("secured exit", 1'b0, otp)
        wr(32'hA3, 8);
        `CHK("customer lock", 1'b1, secur[1])
        factory_lock_i <= 1'b1;
        host.tick(6);
        `CHK("factory lock", 1'b1, secur[0])
        busy <= 1'b1;
        wr(32'h20000000, 32);
        `CHK("busy erase", 3, nreq)
        busy <= 1'b0;
        pp(32'h02000010);
        `CHK("program", 4, nreq)
        `CHK("program addr", 24'h000010, last.addr)
        `CHK("program kind", K_PROG, last.kind)
        `CHK("program byte", 8'h5A, lastb)
        wr(32'hD8000000, 32);
        `CHK("block erase kind", K_BE, last.kind)
        host.frame(32'hA1, 8);
        wr(32'h20000000, 32);
        pp(32'h02000200);
        `CHK("secured refusals", 5, nreq)
        host.frame(32'hA2, 8);
        wr(32'h04, 8);
        `CHK("latch cleared", 1'b0, write_enable_latch)
        host.sel(1'b0);
        host.shift(32'h03000100, 32);
        rd_byte(v);
        host.sel(1'b1);
        `CHK("read data", 8'h3C, v)
        `CHK("read next", 24'h000101, last.addr)
        `CHK("read requests", 7, nreq)
        `CHK("read end", 1'b0, so_oe_o)
        host.sel(1'b0);
        host.shift(32'hA4, 8);
        rd_byte(v);
        host.sel(1'b1);
        `CHK("security read", 8'h03, v)
        host.sel(1'b0);
        host.shift(32'h05, 8);
        rd_byte(v);
        `CHK("status", 8'h04, v)
        host.tick(8);
        `CHK("output on", 1'b1, so_oe_o)
        host.pause(1'b0);
        `CHK("held", 1'b1, held)
        `CHK("output off", 1'b0, so_oe_o)
        host.sel(1'b1);
        `CHK("held cleared", 1'b0, held)
        host.pause(1'b1);
        quad <= 1'b1;
        host.sel(1'b0);
        host.pause(1'b0);
        `CHK("quad no pause", 1'b0, held)
        host.pause(1'b1);
        host.sel(1'b1);
        end_sim();
    end
endmodule
